// [drive_status_outputs_monitor_tb.sv]
/*
 Self-checking bench: random settings against an integer model every
 cycle, then monitor pulse rates measured by the meter.
 Assumes the one-cycle registered answer of the status monitor.
*/
`timescale 1ns/1ns
module drive_status_outputs_monitor_tb;
   logic clk_sys, srst, running, reverse_rotation, overload_alarm_flag, open_motor_flag;
   logic control_method_select, shared_terminal_is_second_set, monitor_source_select;
   logic shared_contact;
   logic [7:0] output_terminal_assign;
   logic [15:0] output_frequency, command_frequency, motor_current, arrival_bandwidth;
   logic [15:0] forward_sensing_level, reverse_sensing_level, accel_reference_frequency;
   logic [15:0] frequency_monitor_reference, current_monitor_reference;
   logic [15:0] accel_time, decel_time, torque_boost, base_frequency;
   logic [15:0] second_accel_time, second_decel_time, second_torque_boost;
   logic [15:0] second_base_frequency;
   logic status_terminal_a_n, status_terminal_b_n, frequency_arrived_flag;
   logic frequency_sensing_flag, output_shutoff_input, second_set_select_input;
   logic eff_boost_base_valid, monitor_pulse_output;
   logic [15:0] eff_accel_time, eff_decel_time, eff_torque_boost, eff_base_frequency;
   logic [15:0] eff_time_reference, edges;
   logic [31:0] period, lfsr;
   int error_cnt, total_checks;

   dsm_status_monitor #(.W(16)) u_dsm_status_monitor (.clk_sys, .srst, .running,
      .reverse_rotation, .overload_alarm_flag, .open_motor_flag, .output_frequency,
      .command_frequency, .motor_current, .output_terminal_assign, .arrival_bandwidth,
      .forward_sensing_level, .reverse_sensing_level, .control_method_select,
      .shared_terminal_is_second_set, .monitor_source_select, .frequency_monitor_reference,
      .current_monitor_reference, .accel_reference_frequency, .accel_time, .decel_time,
      .torque_boost, .base_frequency, .second_accel_time, .second_decel_time,
      .second_torque_boost, .second_base_frequency, .shared_contact, .status_terminal_a_n,
      .status_terminal_b_n, .frequency_arrived_flag, .frequency_sensing_flag,
      .output_shutoff_input, .second_set_select_input, .eff_accel_time, .eff_decel_time,
      .eff_torque_boost, .eff_base_frequency, .eff_boost_base_valid, .eff_time_reference,
      .monitor_pulse_output);
   dsm_meter u_dsm_meter (.clk_sys, .srst, .pulse_in(monitor_pulse_output), .period,
      .edges);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] nxt();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
      return lfsr;
   endfunction

   task automatic fail(input string m);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic chk_period(input logic [31:0] g, input longint e);
      total_checks++;
      // Two cycles of accumulator jitter are allowed either way
      if (g > e + 2 || g + 2 < e) fail("monitor period");
   endtask

   function automatic logic fn(input logic [3:0] c, input logic a, input logic s);
      case (c)
         4'h0: return running;
         4'h1: return a;
         4'h2: return s;
         4'h3: return overload_alarm_flag;
         4'h4: return open_motor_flag;
         default: return 1'b0;
      endcase
   endfunction

   task automatic rnd_step();
      logic [31:0] r;
      r = nxt();
      {running, reverse_rotation, overload_alarm_flag, open_motor_flag} = r[3:0];
      {control_method_select, shared_terminal_is_second_set, shared_contact} = r[6:4];
      monitor_source_select = r[7];
      output_terminal_assign = {1'b0, r[10:8], 1'b0, r[13:11]};
      command_frequency = {6'h0, r[23:14]};
      output_frequency = command_frequency + {10'h0, r[29:24]} - 16'h0020;
      r = nxt();
      arrival_bandwidth = {9'h0, r[6:0]};
      forward_sensing_level = {6'h0, r[16:7]};
      reverse_sensing_level = r[17] ? 16'h270F : {6'h0, r[27:18]};
      r = nxt();
      second_decel_time = r[0] ? 16'h270F : r[31:16];
      {accel_time, decel_time} = nxt();
      {torque_boost, base_frequency} = nxt();
      {second_accel_time, second_torque_boost} = nxt();
      {second_base_frequency, accel_reference_frequency} = nxt();
   endtask

   task automatic chk_all();
      int band, lo, hi;
      logic arr, sen, sel;
      logic [15:0] lvl;
      band = arrival_bandwidth > 100 ? 100 : arrival_bandwidth;
      lo = command_frequency - command_frequency * band / 100;
      hi = command_frequency + command_frequency * band / 100;
      arr = output_frequency >= lo && output_frequency <= hi;
      sel = shared_terminal_is_second_set && shared_contact;
      lvl = forward_sensing_level;
      if (reverse_rotation && reverse_sensing_level !== 16'h270F) lvl = reverse_sensing_level;
      sen = output_frequency > lvl;
      chk_bit(frequency_arrived_flag, arr, "arrived");
      chk_bit(frequency_sensing_flag, sen, "sensing");
      chk_bit(status_terminal_a_n, !fn(output_terminal_assign[3:0], arr, sen),
         "term a");
      chk_bit(status_terminal_b_n, !fn(output_terminal_assign[7:4], arr, sen),
         "term b");
      chk_bit(output_shutoff_input, !shared_terminal_is_second_set && shared_contact,
         "shut");
      chk_bit(second_set_select_input, sel, "select");
      chk_word(eff_accel_time, sel ? second_accel_time : accel_time, "accel");
      chk_word(eff_decel_time, !sel ? decel_time : second_decel_time === 16'h270F ?
         second_accel_time : second_decel_time, "decel");
      chk_word(eff_torque_boost, control_method_select ? 16'h0 :
         sel ? second_torque_boost : torque_boost, "boost");
      chk_word(eff_base_frequency, control_method_select ? 16'h0 :
         sel ? second_base_frequency : base_frequency, "base");
      chk_bit(eff_boost_base_valid, !control_method_select, "valid");
      chk_word(eff_time_reference, accel_reference_frequency, "time ref");
   endtask

   task automatic mon(input logic s, input logic [15:0] v, input logic [15:0] rf);
      int n;
      logic [15:0] k;
      longint e;
      monitor_source_select = s;
      output_frequency = s ? 16'h0 : v;
      motor_current = s ? v : 16'h0;
      // The unused reference is set to junk to show it has no effect
      frequency_monitor_reference = s ? 16'h1234 : rf;
      current_monitor_reference = s ? rf : 16'h4321;
      k = edges + 16'h3;
      n = 0;
      while (edges !== k && n < 40000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      e = 0;
      if (v != 0) e = longint'(100000000) * rf / (1440 * v);
      if (v != 0) chk_period(period, e);
      else chk_word(edges, k - 16'h3, "pulse at zero");
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      // Random phase, two rate runs and a 40000-cycle zero run
      #900000;
      fail("watchdog");
      conclude();
   end

   initial begin
      lfsr = 32'h1f2a;
      error_cnt = 0;
      total_checks = 0;
      srst = 1'b1;
      motor_current = 16'h0;
      frequency_monitor_reference = 16'h1770;
      current_monitor_reference = 16'h0064;
      rnd_step();
      repeat (16) @(posedge clk_sys);
      #1;
      chk_bit(status_terminal_a_n, 1'b1, "reset term");
      chk_bit(frequency_arrived_flag, 1'b0, "reset flag");
      srst = 1'b0;
      repeat (3000) begin
         rnd_step();
         @(posedge clk_sys);
         #1;
         chk_all();
      end
      mon(1'b0, 16'h2710, 16'h03E8);
      mon(1'b1, 16'h2710, 16'h01F4);
      mon(1'b1, 16'h0000, 16'h01F4);
      conclude();
   end
endmodule

// [dsm_map.svh]
/*
 Constants for the drive status outputs monitor: setting codes,
 reset values, sentinel values and monitor timing.
 Assumes inclusion by the design modules only, not by dsm_pkg.sv.
*/
// Function
// - Two digits pick each status terminal function
// - Arrived flag active within bandwidth of command
// - Bandwidth zero to 100 percent, symmetric
// - Sensing output low above level, high below
// - Reverse level used only in reverse rotation
// - Reverse level 9999 means use forward level
// - Second-set input switches four settings together
// - Second decel 9999 means use second accel
// - Flux vector mode ignores boost and base
// - Second times reference the accel reference frequency
// - Shared terminal defaults to output shutoff
// - Monitor source 0 frequency, 1 current
// - Frequency reference gives 1440 Hz full scale
// - Current reference gives 1440 Hz full scale
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH

`define DSM_FN_RUN          4'h0
`define DSM_FN_ARRIVED      4'h1
`define DSM_FN_SENSING      4'h2
`define DSM_FN_OVERLOAD     4'h3
`define DSM_FN_OPEN_MOTOR   4'h4
`define DSM_ASSIGN_LO       3:0
`define DSM_ASSIGN_HI       7:4
`define DSM_ASSIGN_RESET    8'h02
`define DSM_UNSET           16'h270F
`define DSM_BAND_MAX        16'h0064
`define DSM_PCT_FULL        32'h0000_0064
`define DSM_FREQ_REF_RESET  16'h1770
`define DSM_SRC_FREQ        1'b0
`define DSM_SRC_CURR        1'b1
`define DSM_FULL_SCALE_HZ   32'd1440
`define DSM_CLK_HZ          32'd100000000

`endif

// [dsm_meter.sv]
/*
 Behavioural pulse meter on the monitor terminal: counts rising edges
 and the clk_sys cycles between the last two of them.
 Assumes the pulse input is synchronous to clk_sys.
*/
`timescale 1ns/1ns
module dsm_meter (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // Monitored pulse train
   input  wire logic        pulse_in,
   // Measurement
   output logic [31:0]      period,
   output logic [15:0]      edges
);
   logic        prev;
   logic [31:0] cnt;
   // Meter only listens; no rule binds this side
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev   <= 1'b0;
         cnt    <= 32'h0;
         period <= 32'h0;
         edges  <= 16'h0;
      end else begin
         prev <= pulse_in;
         cnt  <= cnt + 32'h1;
         if (pulse_in && !prev) begin
            period <= cnt + 32'h1;
            cnt    <= 32'h0;
            edges  <= edges + 16'h1;
         end
      end
   end
endmodule

// [dsm_pkg.sv]
/*
 Types shared by the status outputs monitor.
 Assumes dsm_map.svh is on the include path.
*/
package dsm_pkg;
   typedef enum logic [1:0] {
      DSM_PULSE_LOW  = 2'b01,
      DSM_PULSE_HIGH = 2'b10
   } dsm_pulse_t;
endpackage

// [dsm_pulse_gen.sv]
/*
 Pulse-train generator for the monitor output: a phase accumulator whose
 step is proportional to value/reference.
 Assumes synchronous inputs on clk_sys and a stable reference.
*/
`timescale 1ns/1ns
`include "dsm_map.svh"
module dsm_pulse_gen #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // Quantity
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] reference,
   // Pulse train
   output logic              pulse
);
   localparam int ACC_W = 40;
   localparam logic [ACC_W-1:0] PHASE_FULL = 40'h80_0000_0000;
   initial begin
      if (W < 4 || W > 24) $error("dsm_pulse_gen: W out of range");
   end

   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic [ACC_W-1:0] step;
   logic             next_pulse;
   dsm_pkg::dsm_pulse_t state;
   dsm_pkg::dsm_pulse_t next_state;

   // Step = 2^40 * 1440 * value / (ref * fclk), one output period per wrap
   always_comb begin
      // 96 bits: value * 1440 shifted by 40 overflows a 64-bit product
      logic [95:0] num;
      num = 96'h0;
      step = '0;
      if (reference != '0) begin
         num = (96'(value) * 96'(`DSM_FULL_SCALE_HZ)) << ACC_W;
         step = ACC_W'(num / (96'(reference) * 96'(`DSM_CLK_HZ)));
      end
      next_acc = acc + step;
      next_pulse = next_acc[ACC_W-1];
      case (state)
         dsm_pkg::DSM_PULSE_LOW:  next_state = next_pulse ? dsm_pkg::DSM_PULSE_HIGH : state;
         dsm_pkg::DSM_PULSE_HIGH: next_state = next_pulse ? state : dsm_pkg::DSM_PULSE_LOW;
         default:                 next_state = dsm_pkg::DSM_PULSE_LOW;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc <= '0;
         state <= dsm_pkg::DSM_PULSE_LOW;
      end else begin
         acc <= next_acc;
         state <= next_state;
      end
   end

   assign pulse = (state == dsm_pkg::DSM_PULSE_HIGH);

   property p_zero_still;
      @(posedge clk_sys) disable iff (srst) (value == '0) [*3] |-> $stable(acc);
   endproperty
   a_zero_still: assert property (p_zero_still) else $error("pulse moved at zero");
   c_toggle: cover property (@(posedge clk_sys) disable iff (srst) $rose(pulse));
   wire unused_full = PHASE_FULL[0];
endmodule

// [dsm_status_monitor.sv]
/*
 Drive status outputs: terminal assignment, frequency arrived and sensing,
 second parameter set selection and the monitor pulse output.
 Assumes all settings and drive quantities are synchronous to clk_sys;
 frequencies in 0.01 Hz units, bandwidth in percent.
*/
`timescale 1ns/1ns
`include "dsm_map.svh"
module dsm_status_monitor #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // Drive state
   input  wire logic         running,
   input  wire logic         reverse_rotation,
   input  wire logic         overload_alarm_flag,
   input  wire logic         open_motor_flag,
   input  wire logic [W-1:0] output_frequency,
   input  wire logic [W-1:0] command_frequency,
   input  wire logic [W-1:0] motor_current,
   // Settings
   input  wire logic [7:0]   output_terminal_assign,
   input  wire logic [W-1:0] arrival_bandwidth,
   input  wire logic [W-1:0] forward_sensing_level,
   input  wire logic [W-1:0] reverse_sensing_level,
   input  wire logic         control_method_select,
   input  wire logic         shared_terminal_is_second_set,
   input  wire logic         monitor_source_select,
   input  wire logic [W-1:0] frequency_monitor_reference,
   input  wire logic [W-1:0] current_monitor_reference,
   input  wire logic [W-1:0] accel_reference_frequency,
   // Parameter sets
   input  wire logic [W-1:0] accel_time,
   input  wire logic [W-1:0] decel_time,
   input  wire logic [W-1:0] torque_boost,
   input  wire logic [W-1:0] base_frequency,
   input  wire logic [W-1:0] second_accel_time,
   input  wire logic [W-1:0] second_decel_time,
   input  wire logic [W-1:0] second_torque_boost,
   input  wire logic [W-1:0] second_base_frequency,
   // Shared contact terminal, high when closed to contact_common
   input  wire logic         shared_contact,
   // Status terminals, low means conducting; flags and decoded inputs high when active
   output logic              status_terminal_a_n,
   output logic              status_terminal_b_n,
   output logic              frequency_arrived_flag,
   output logic              frequency_sensing_flag,
   output logic              output_shutoff_input,
   output logic              second_set_select_input,
   // Effective settings
   output logic [W-1:0]      eff_accel_time,
   output logic [W-1:0]      eff_decel_time,
   output logic [W-1:0]      eff_torque_boost,
   output logic [W-1:0]      eff_base_frequency,
   output logic              eff_boost_base_valid,
   output logic [W-1:0]      eff_time_reference,
   // Monitor
   output logic              monitor_pulse_output
);
   initial begin
      if (W < 14 || W > 24) $error("dsm_status_monitor: W must hold 9999");
   end

   function automatic logic pick(input logic [3:0] code, input logic [4:0] fn);
      case (code)
         `DSM_FN_RUN:        pick = fn[0];
         `DSM_FN_ARRIVED:    pick = fn[1];
         `DSM_FN_SENSING:    pick = fn[2];
         `DSM_FN_OVERLOAD:   pick = fn[3];
         `DSM_FN_OPEN_MOTOR: pick = fn[4];
         default:            pick = 1'b0;
      endcase
   endfunction

   logic [W-1:0] band;
   logic [W+7:0] band_width;
   logic [W+1:0] lo_edge;
   logic [W+1:0] hi_edge;
   logic         next_arrived;
   logic         next_sensing;
   logic [W-1:0] sense_level;
   logic         next_a;
   logic         next_b;
   logic         next_sec;
   logic         next_shut;
   logic [W-1:0] next_acc_t;
   logic [W-1:0] next_dec_t;
   logic [W-1:0] next_boost;
   logic [W-1:0] next_base;
   logic [W-1:0] mon_value;
   logic [W-1:0] mon_ref;
   logic [4:0]   fn;

   always_comb begin
      // Clamp keeps the window within one times the command
      band = (arrival_bandwidth > W'(`DSM_BAND_MAX)) ? W'(`DSM_BAND_MAX)
                                                    : arrival_bandwidth;
      band_width = (W+8)'((32'(command_frequency) * 32'(band)) / `DSM_PCT_FULL);
      lo_edge = (W+2)'(command_frequency) - (W+2)'(band_width);
      hi_edge = (W+2)'(command_frequency) + (W+2)'(band_width);
      if (band_width > (W+8)'(command_frequency))
         lo_edge = '0;
      next_arrived = ((W+2)'(output_frequency) >= lo_edge) &&
                     ((W+2)'(output_frequency) <= hi_edge);
      if (reverse_rotation && reverse_sensing_level != W'(`DSM_UNSET))
         sense_level = reverse_sensing_level;
      else
         sense_level = forward_sensing_level;
      next_sensing = output_frequency > sense_level;
      fn = {open_motor_flag, overload_alarm_flag, next_sensing, next_arrived, running};
      next_a = ~pick(output_terminal_assign[`DSM_ASSIGN_LO], fn);
      next_b = ~pick(output_terminal_assign[`DSM_ASSIGN_HI], fn);
      next_sec = shared_terminal_is_second_set & shared_contact;
      next_shut = ~shared_terminal_is_second_set & shared_contact;
      if (next_sec) begin
         next_acc_t = second_accel_time;
         next_dec_t = (second_decel_time == W'(`DSM_UNSET)) ? second_accel_time
                                                            : second_decel_time;
         next_boost = second_torque_boost;
         next_base = second_base_frequency;
      end else begin
         next_acc_t = accel_time;
         next_dec_t = decel_time;
         next_boost = torque_boost;
         next_base = base_frequency;
      end
      if (control_method_select) begin
         next_boost = '0;
         next_base = '0;
      end
      mon_value = (monitor_source_select == `DSM_SRC_CURR) ? motor_current
                                                           : output_frequency;
      mon_ref = (monitor_source_select == `DSM_SRC_CURR) ? current_monitor_reference
                                                         : frequency_monitor_reference;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         frequency_arrived_flag <= 1'b0;
         frequency_sensing_flag <= 1'b0;
         status_terminal_a_n <= 1'b1;
         status_terminal_b_n <= 1'b1;
         second_set_select_input <= 1'b0;
         output_shutoff_input <= 1'b0;
         eff_accel_time <= '0;
         eff_decel_time <= '0;
         eff_torque_boost <= '0;
         eff_base_frequency <= '0;
         eff_boost_base_valid <= 1'b0;
         eff_time_reference <= '0;
      end else begin
         frequency_arrived_flag <= next_arrived;
         frequency_sensing_flag <= next_sensing;
         status_terminal_a_n <= next_a;
         status_terminal_b_n <= next_b;
         second_set_select_input <= next_sec;
         output_shutoff_input <= next_shut;
         eff_accel_time <= next_acc_t;
         eff_decel_time <= next_dec_t;
         eff_torque_boost <= next_boost;
         eff_base_frequency <= next_base;
         eff_boost_base_valid <= ~control_method_select;
         // Both sets share one time base
         eff_time_reference <= accel_reference_frequency;
      end
   end

   dsm_pulse_gen #(.W(W)) u_pulse (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .value     (mon_value),
      .reference (mon_ref),
      .pulse     (monitor_pulse_output)
   );

   property p_arrive;
      @(posedge clk_sys) disable iff (srst)
         (output_frequency == command_frequency) |=> frequency_arrived_flag;
   endproperty
   a_arrive: assert property (p_arrive) else $error("arrival missed");

   property p_sense;
      @(posedge clk_sys) disable iff (srst)
         (!reverse_rotation && output_frequency > forward_sensing_level) |=> frequency_sensing_flag;
   endproperty
   a_sense: assert property (p_sense) else $error("sensing missed");

   property p_rev_unset;
      @(posedge clk_sys) disable iff (srst)
         (reverse_sensing_level == W'(`DSM_UNSET) && output_frequency <= forward_sensing_level)
         |=> !frequency_sensing_flag;
   endproperty
   a_rev_unset: assert property (p_rev_unset) else $error("unset reverse misused");

   property p_rev_used;
      @(posedge clk_sys) disable iff (srst)
         (reverse_rotation && reverse_sensing_level != W'(`DSM_UNSET) &&
          output_frequency > reverse_sensing_level) |=> frequency_sensing_flag;
   endproperty
   a_rev_used: assert property (p_rev_used) else $error("reverse level ignored");

   property p_term_a;
      @(posedge clk_sys) disable iff (srst)
         (output_terminal_assign[`DSM_ASSIGN_LO] == `DSM_FN_RUN) |=>
            (status_terminal_a_n == !$past(running));
   endproperty
   a_term_a: assert property (p_term_a) else $error("terminal a wrong");

   property p_set2;
      @(posedge clk_sys) disable iff (srst)
         second_set_select_input |-> (eff_accel_time == $past(second_accel_time));
   endproperty
   a_set2: assert property (p_set2) else $error("second set not used");

   property p_dec9999;
      @(posedge clk_sys) disable iff (srst)
         (shared_terminal_is_second_set && shared_contact &&
          second_decel_time == W'(`DSM_UNSET)) |=> (eff_decel_time == $past(second_accel_time));
   endproperty
   a_dec9999: assert property (p_dec9999) else $error("decel default wrong");

   property p_shut;
      @(posedge clk_sys) disable iff (srst)
         !shared_terminal_is_second_set |=> !second_set_select_input;
   endproperty
   a_shut: assert property (p_shut) else $error("second set without reassign");

   property p_flux;
      @(posedge clk_sys) disable iff (srst)
         control_method_select |=> (eff_torque_boost == '0 && !eff_boost_base_valid);
   endproperty
   a_flux: assert property (p_flux) else $error("boost not ignored");

   property p_term_b;
      @(posedge clk_sys) disable iff (srst)
         (output_terminal_assign[`DSM_ASSIGN_HI] == `DSM_FN_RUN) |=>
            (status_terminal_b_n == !$past(running));
   endproperty
   a_term_b: assert property (p_term_b) else $error("terminal b wrong");

   property p_term_open;
      @(posedge clk_sys) disable iff (srst)
         (output_terminal_assign[`DSM_ASSIGN_LO] > `DSM_FN_OPEN_MOTOR) |=> status_terminal_a_n;
   endproperty
   a_term_open: assert property (p_term_open) else $error("unknown code drives");

   // Beyond twice the command no bandwidth setting can reach
   property p_band_out;
      @(posedge clk_sys) disable iff (srst)
         ((W+2)'(output_frequency) > ((W+2)'(command_frequency) << 1)) |=>
            !frequency_arrived_flag;
   endproperty
   a_band_out: assert property (p_band_out) else $error("arrived outside band");

   property p_sense_low;
      @(posedge clk_sys) disable iff (srst)
         (!reverse_rotation && output_frequency <= forward_sensing_level) |=>
            !frequency_sensing_flag;
   endproperty
   a_sense_low: assert property (p_sense_low) else $error("sensing above level");

   property p_set1;
      @(posedge clk_sys) disable iff (srst)
         (!second_set_select_input && !$past(srst)) |->
            (eff_accel_time == $past(accel_time));
   endproperty
   a_set1: assert property (p_set1) else $error("primary set not used");

   property p_flux_base;
      @(posedge clk_sys) disable iff (srst)
         control_method_select |=> (eff_base_frequency == '0);
   endproperty
   a_flux_base: assert property (p_flux_base) else $error("base not ignored");

   property p_shut_on;
      @(posedge clk_sys) disable iff (srst)
         (!shared_terminal_is_second_set && shared_contact) |=> output_shutoff_input;
   endproperty
   a_shut_on: assert property (p_shut_on) else $error("shutoff missed");

   property p_time_ref;
      @(posedge clk_sys) disable iff (srst)
         1'b1 |=> (eff_time_reference == $past(accel_reference_frequency));
   endproperty
   a_time_ref: assert property (p_time_ref) else $error("time reference wrong");


   c_arrived: cover property (@(posedge clk_sys) disable iff (srst) $rose(frequency_arrived_flag));
   c_reverse: cover property (@(posedge clk_sys) disable iff (srst)
      reverse_rotation && frequency_sensing_flag);
   c_second: cover property (@(posedge clk_sys) disable iff (srst) $rose(second_set_select_input));
   c_current: cover property (@(posedge clk_sys) disable iff (srst)
      monitor_source_select && monitor_pulse_output);
endmodule
